// ===== rtl/afo_defines.svh
`ifndef AFO_DEFINES_SVH
`define AFO_DEFINES_SVH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define AFO_ADDR_X_LOW 8'h02
`define AFO_ADDR_X_HIGH 8'h03
`define AFO_ADDR_Y_LOW 8'h04
`define AFO_ADDR_Y_HIGH 8'h05
`define AFO_ADDR_Z_LOW 8'h06
`define AFO_ADDR_Z_HIGH 8'h07
`define AFO_ADDR_OFS_CTRL 8'h36
`define AFO_ADDR_OFS_X 8'h38
`define AFO_ADDR_OFS_Y 8'h39
`define AFO_ADDR_OFS_Z 8'h3A
`define AFO_ADDR_WM 8'h3D
`define AFO_ADDR_CFG 8'h3E
`define AFO_ADDR_PORT 8'h3F

// ---------------------------------------------------------------
// Field positions and reset values
// ---------------------------------------------------------------
`define AFO_OFS_CLR_BIT 7
`define AFO_MODE_MSB 7
`define AFO_MODE_LSB 5
`define AFO_IVAL_MSB 3
`define AFO_IVAL_LSB 2
`define AFO_SEL_MSB 1
`define AFO_SEL_LSB 0
`define AFO_WM_MSB 6
`define AFO_REG_RST 8'h00
`define AFO_WM_RST 7'h00
`define AFO_CFG_RST 8'h00
`define AFO_FIFO_DEPTH 32

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define AFO_CLK_PERIOD_NS 4
`define AFO_NS_HIGH_NS 250000
`define AFO_NS_LOW_NS 50000

`endif

// ===== rtl/afo_pkg.sv
package afo_pkg;

  // Buffer fill modes, codes as stored in the configuration register
  typedef enum logic [2:0] {
    AFO_MODE_BYPASS = 3'b000,
    AFO_MODE_FILL_STOP = 3'b001,
    AFO_MODE_RSVD_2 = 3'b010,
    AFO_MODE_STREAM_STOP = 3'b011,
    AFO_MODE_BYPASS_STREAM = 3'b100,
    AFO_MODE_RSVD_5 = 3'b101,
    AFO_MODE_STREAM = 3'b110,
    AFO_MODE_RSVD_7 = 3'b111
  } afo_mode_e;

  // One raw 12-bit three-axis sample
  typedef struct packed {
    logic [11:0] x;
    logic [11:0] y;
    logic [11:0] z;
  } afo_sample_s;

  // One buffered frame; single-axis frames use slot x only
  typedef struct packed {
    logic [15:0] x;
    logic [15:0] y;
    logic [15:0] z;
  } afo_frame_s;

  // One register access from the serial interface logic
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } afo_reg_req_s;

endpackage

// ===== rtl/afo_accel_fifo.sv
`timescale 1ns/1ps
`include "afo_defines.svh"

// What this block does
// RULE1: Output register holds sample plus signed offset.
// RULE2: Offset registers 8-bit, read/write, reset zero.
// RULE3: Offset-clear bit zeroes all three offsets.
// RULE4: Watermark interrupt when unread frames equal level.
// RULE5: Watermark level zero disables watermark interrupt.
// RULE6: Watermark write flushes buffer, clears flags.
// RULE7: Configuration write flushes buffer, clears flags.
// RULE8: Mode field selects bypass, fill, stream variants.
// RULE9: Subsampling stores one of 1/2/4/8 samples.
// RULE10: Source field picks all axes or one.
// RULE11: Three-axis frame reads X, Y, Z low-high.
// RULE12: Single-axis frames read low-high, frame by frame.
// RULE13: Read port read-only, output-register byte layout.
// RULE14: Burst at read port keeps address fixed.
// RULE15: Partly read frame is discarded whole.
// RULE16: New-sample flag rises after Z stored.
// RULE17: New-sample flag clears at next acquisition.
// RULE18: New-sample flag low at least 50 us.
// RULE19: New-sample pulse non-latched, at least 250 us.
// RULE20: Enable bit gates the new-sample interrupt.
// RULE21: Route bits map new-sample to either output.
// RULE22: Setup bit picks unfiltered or filtered source.
// RULE23: Fill mode stops and flags overrun; stream drops.
// RULE24: Bypass holds no frames, no watermark.
module afo_accel_fifo
  import afo_pkg::*;
#(
  parameter int unsigned DEPTH = `AFO_FIFO_DEPTH,
  parameter int unsigned NS_HIGH_CYC =
    (`AFO_NS_HIGH_NS + `AFO_CLK_PERIOD_NS - 1) / `AFO_CLK_PERIOD_NS,
  parameter int unsigned NS_LOW_CYC =
    (`AFO_NS_LOW_NS + `AFO_CLK_PERIOD_NS - 1) / `AFO_CLK_PERIOD_NS
) (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire afo_sample_s filt_sample_i,
  input wire logic filt_valid_i,
  input wire afo_sample_s unf_sample_i,
  input wire logic unf_valid_i,
  input wire logic acq_start_i,
  input wire logic motion_trig_i,
  input wire afo_reg_req_s reg_req_i,
  input wire logic reg_burst_end_i,
  input wire logic ns_enable_i,
  input wire logic new_sample_route_out1_i,
  input wire logic new_sample_route_out2_i,
  input wire logic unfiltered_sel_i,
  output logic [7:0] reg_rdata_o,
  output logic [7:0] reg_next_addr_o,
  output logic new_sample_irq_flag_o,
  output logic irq_output_one_o,
  output logic irq_output_two_o,
  output logic wm_irq_o,
  output logic full_irq_o,
  output logic overrun_o,
  output logic [6:0] frame_count_o
);

  localparam int AW = $clog2(DEPTH);

  // ---------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------
  // Signed offset added to a 12-bit sample, wrapping at 12 bits
  function automatic logic [11:0] add_ofs(input logic [11:0] raw,
                                          input logic [7:0] ofs);
    add_ofs = raw + {{4{ofs[7]}}, ofs};
  endfunction

  // Bytes in one frame for a given source selection
  function automatic logic [2:0] frame_len(input logic [1:0] sel);
    frame_len = (sel == 2'h0) ? 3'h6 : 3'h2;
  endfunction

  // Byte of a frame by index: x low, x high, y low, ...
  function automatic logic [7:0] pick_byte(input afo_frame_s f,
                                           input logic [2:0] idx);
    case (idx)
      3'h0: pick_byte = f.x[7:0];
      3'h1: pick_byte = f.x[15:8];
      3'h2: pick_byte = f.y[7:0];
      3'h3: pick_byte = f.y[15:8];
      3'h4: pick_byte = f.z[7:0];
      default: pick_byte = f.z[15:8];
    endcase
  endfunction

  // Pointer step with wrap at the buffer depth
  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [7:0] x_offset_value_q; // Signed X offset
  logic [7:0] y_offset_value_q; // Signed Y offset
  logic [7:0] z_offset_value_q; // Signed Z offset
  logic [15:0] x_accel_output_q; // X output, flag in bit 0
  logic [15:0] y_accel_output_q; // Y output
  logic [15:0] z_accel_output_q; // Z output
  logic [6:0] watermark_level_q; // Programmed watermark
  logic [7:0] cfg_q; // Mode, interval, source
  afo_frame_s mem_q [DEPTH]; // Frame storage
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0] cnt_q; // Unread frames
  logic [2:0] byte_idx_q; // Next byte of head frame
  logic [2:0] sub_cnt_q; // Subsampling phase
  logic trig_seen_q; // Motion event seen since flush
  logic overrun_q;
  logic wm_q;
  logic full_q;
  logic ns_q; // New-sample pulse
  logic [16:0] ns_cnt_q; // Hold counter for either level
  logic ns_clr_pend_q; // Acquisition start while held high
  logic ns_set_pend_q; // Store while held low
  logic [7:0] rdata_q;
  logic [7:0] next_addr_q;
  logic irq1_q;
  logic irq2_q;

  // ---------------------------------------------------------------
  // Register decode
  // ---------------------------------------------------------------
  wire wr_go = ce_i && reg_req_i.wr;
  wire rd_go = ce_i && reg_req_i.rd;
  wire [7:0] addr = reg_req_i.addr;
  wire [7:0] wdata = reg_req_i.wdata;
  wire ofs_clr = wr_go && addr == `AFO_ADDR_OFS_CTRL &&
                 wdata[`AFO_OFS_CLR_BIT];
  wire wr_wm = wr_go && addr == `AFO_ADDR_WM;
  wire wr_cfg = wr_go && addr == `AFO_ADDR_CFG;
  // RULE6 flush source, RULE7 likewise
  wire flush = wr_wm || wr_cfg;
  afo_mode_e mode;
  assign mode = afo_mode_e'(cfg_q[`AFO_MODE_MSB:`AFO_MODE_LSB]);
  wire [1:0] ival = cfg_q[`AFO_IVAL_MSB:`AFO_IVAL_LSB];
  wire [1:0] src_sel = cfg_q[`AFO_SEL_MSB:`AFO_SEL_LSB];

  // ---------------------------------------------------------------
  // Sample path
  // ---------------------------------------------------------------
  // RULE22 source choice
  wire afo_sample_s smp = unfiltered_sel_i ? unf_sample_i : filt_sample_i;
  wire store = ce_i && (unfiltered_sel_i ? unf_valid_i : filt_valid_i);
  // RULE1 offset added; low byte keeps new-sample flag set
  wire [15:0] x_new = {add_ofs(smp.x, x_offset_value_q), 3'h0, 1'b1};
  wire [15:0] y_new = {add_ofs(smp.y, y_offset_value_q), 3'h0, 1'b1};
  wire [15:0] z_new = {add_ofs(smp.z, z_offset_value_q), 3'h0, 1'b1};

  // Offsets: host writes, clear bit, reset
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      // RULE2 reset to zero
      x_offset_value_q <= `AFO_REG_RST;
      y_offset_value_q <= `AFO_REG_RST;
      z_offset_value_q <= `AFO_REG_RST;
    end else if (ofs_clr) begin
      // RULE3 clear all offsets
      x_offset_value_q <= `AFO_REG_RST;
      y_offset_value_q <= `AFO_REG_RST;
      z_offset_value_q <= `AFO_REG_RST;
    end else if (wr_go) begin
      if (addr == `AFO_ADDR_OFS_X) x_offset_value_q <= wdata;
      if (addr == `AFO_ADDR_OFS_Y) y_offset_value_q <= wdata;
      if (addr == `AFO_ADDR_OFS_Z) z_offset_value_q <= wdata;
    end
  end

  // Output registers; a store beats the flag clear of a low-byte read
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      x_accel_output_q <= '0;
      y_accel_output_q <= '0;
      z_accel_output_q <= '0;
    end else if (store) begin
      x_accel_output_q <= x_new;
      y_accel_output_q <= y_new;
      z_accel_output_q <= z_new;
    end else if (rd_go) begin
      if (addr == `AFO_ADDR_X_LOW) x_accel_output_q[0] <= 1'b0;
      if (addr == `AFO_ADDR_Y_LOW) y_accel_output_q[0] <= 1'b0;
      if (addr == `AFO_ADDR_Z_LOW) z_accel_output_q[0] <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Buffer control
  // ---------------------------------------------------------------
  logic stop_mode;
  logic stream_mode;
  // RULE8 mode decode; reserved codes act as bypass
  always_comb begin
    stop_mode = 1'b0;
    stream_mode = 1'b0;
    case (mode)
      AFO_MODE_FILL_STOP: stop_mode = 1'b1;
      AFO_MODE_STREAM_STOP: begin
        stop_mode = trig_seen_q;
        stream_mode = !trig_seen_q;
      end
      AFO_MODE_BYPASS_STREAM: stream_mode = trig_seen_q;
      AFO_MODE_STREAM: stream_mode = 1'b1;
      default: begin
        stop_mode = 1'b0;
        stream_mode = 1'b0;
      end
    endcase
  end

  // RULE9 one stored frame per 1, 2, 4 or 8 samples
  wire [2:0] sub_mask = 3'((4'h1 << ival) - 4'h1);
  wire take = store && ((sub_cnt_q & sub_mask) == 3'h0) && !flush;
  wire full = cnt_q == (AW+1)'(DEPTH);
  wire empty = cnt_q == '0;
  // RULE24 nothing enters in bypass
  wire push = take && (stream_mode || (stop_mode && !full));
  // RULE23 fill mode refuses, stream mode drops the oldest
  wire ovr_set = take && stop_mode && full;
  wire [2:0] flen = frame_len(src_sel);
  wire rd_port = rd_go && addr == `AFO_ADDR_PORT && !empty && !flush;
  wire pop_rd = rd_port && byte_idx_q == flen - 3'h1;
  // RULE15 burst ended mid-frame: drop the rest of it
  wire pop_part = ce_i && reg_burst_end_i && byte_idx_q != 3'h0 &&
                  !empty && !flush;
  wire pop = pop_rd || pop_part;
  wire drop_old = push && full && !pop;
  wire [AW:0] cnt_d = flush ? '0 :
    cnt_q + (AW+1)'(push && !drop_old) - (AW+1)'(pop);

  // RULE10 frame contents follow the source selection
  afo_frame_s frame_w;
  always_comb begin
    frame_w = '{x: x_new, y: y_new, z: z_new};
    case (src_sel)
      2'h1: frame_w = '{x: x_new, y: 16'h0000, z: 16'h0000};
      2'h2: frame_w = '{x: y_new, y: 16'h0000, z: 16'h0000};
      2'h3: frame_w = '{x: z_new, y: 16'h0000, z: 16'h0000};
      default: frame_w = '{x: x_new, y: y_new, z: z_new};
    endcase
  end

  // Frame storage
  always_ff @(posedge ref_clk_i) begin
    if (push) mem_q[wr_ptr_q] <= frame_w;
  end

  // Pointers, count and byte index
  always_ff @(posedge ref_clk_i) begin
    if (srst_i || flush) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      cnt_q <= '0;
      byte_idx_q <= 3'h0;
    end else if (ce_i) begin
      cnt_q <= cnt_d;
      if (push) wr_ptr_q <= ptr_inc(wr_ptr_q);
      if (pop || drop_old) rd_ptr_q <= ptr_inc(rd_ptr_q);
      // RULE11 RULE12 walk through the frame bytes
      if (pop || drop_old) byte_idx_q <= 3'h0;
      else if (rd_port) byte_idx_q <= byte_idx_q + 3'h1;
    end
  end

  // Subsampling phase and trigger latch
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      sub_cnt_q <= 3'h0;
      trig_seen_q <= 1'b0;
    end else if (ce_i) begin
      if (store) sub_cnt_q <= sub_cnt_q + 3'h1;
      if (motion_trig_i) trig_seen_q <= 1'b1;
      else if (flush) trig_seen_q <= 1'b0;
    end
  end

  // Buffer flags; hardware sets win over flush clears
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      overrun_q <= 1'b0;
      wm_q <= 1'b0;
      full_q <= 1'b0;
    end else if (ce_i) begin
      if (ovr_set) overrun_q <= 1'b1;
      else if (flush) overrun_q <= 1'b0;
      // RULE4 RULE5 level reached, level not zero
      if (watermark_level_q != 7'h00 && 7'(cnt_d) == watermark_level_q &&
          7'(cnt_q) != watermark_level_q) wm_q <= 1'b1;
      else if (flush) wm_q <= 1'b0;
      if (cnt_d == (AW+1)'(DEPTH) && !full) full_q <= 1'b1;
      else if (flush) full_q <= 1'b0;
    end
  end

  // Watermark and configuration registers
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      watermark_level_q <= `AFO_WM_RST;
      cfg_q <= `AFO_CFG_RST;
    end else begin
      if (wr_wm) watermark_level_q <= wdata[`AFO_WM_MSB:0];
      if (wr_cfg) cfg_q <= {wdata[7:5], 1'b0, wdata[3:0]};
    end
  end

  // ---------------------------------------------------------------
  // Register read
  // ---------------------------------------------------------------
  // RULE13 read port uses the output-register byte layout
  wire [7:0] port_byte = empty ? 8'h00 :
    pick_byte(mem_q[rd_ptr_q], byte_idx_q);
  logic [7:0] rd_mux;
  always_comb begin
    case (addr)
      `AFO_ADDR_X_LOW: rd_mux = x_accel_output_q[7:0];
      `AFO_ADDR_X_HIGH: rd_mux = x_accel_output_q[15:8];
      `AFO_ADDR_Y_LOW: rd_mux = y_accel_output_q[7:0];
      `AFO_ADDR_Y_HIGH: rd_mux = y_accel_output_q[15:8];
      `AFO_ADDR_Z_LOW: rd_mux = z_accel_output_q[7:0];
      `AFO_ADDR_Z_HIGH: rd_mux = z_accel_output_q[15:8];
      `AFO_ADDR_OFS_X: rd_mux = x_offset_value_q;
      `AFO_ADDR_OFS_Y: rd_mux = y_offset_value_q;
      `AFO_ADDR_OFS_Z: rd_mux = z_offset_value_q;
      `AFO_ADDR_WM: rd_mux = {1'b0, watermark_level_q};
      `AFO_ADDR_CFG: rd_mux = cfg_q;
      `AFO_ADDR_PORT: rd_mux = port_byte;
      default: rd_mux = 8'h00;
    endcase
  end

  // Read data and next burst address, one cycle after the request
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      rdata_q <= 8'h00;
      next_addr_q <= 8'h00;
    end else if (rd_go) begin
      rdata_q <= rd_mux;
      // RULE14 read port address does not advance
      next_addr_q <= (addr == `AFO_ADDR_PORT) ? addr : addr + 8'h01;
    end
  end

  // ---------------------------------------------------------------
  // New-sample interrupt
  // ---------------------------------------------------------------
  wire ns_hold = ns_cnt_q != 17'h0;
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      ns_q <= 1'b0;
      ns_cnt_q <= 17'h0;
      ns_clr_pend_q <= 1'b0;
      ns_set_pend_q <= 1'b0;
    end else if (ce_i) begin
      if (ns_hold) ns_cnt_q <= ns_cnt_q - 17'h1;
      if (ns_q) begin
        // RULE17 RULE19 clear at acquisition start after minimum high
        if (!ns_hold && (ns_clr_pend_q || acq_start_i)) begin
          ns_q <= 1'b0;
          ns_cnt_q <= 17'(NS_LOW_CYC - 1);
          ns_clr_pend_q <= 1'b0;
        end else if (acq_start_i) begin
          ns_clr_pend_q <= 1'b1;
        end
      end else if (!ns_enable_i) begin
        // RULE20 disabled: nothing pending
        ns_set_pend_q <= 1'b0;
      end else if (!ns_hold && (store || ns_set_pend_q)) begin
        // RULE16 RULE18 rise after Z stored, after minimum low
        ns_q <= 1'b1;
        ns_cnt_q <= 17'(NS_HIGH_CYC - 1);
        ns_set_pend_q <= 1'b0;
      end else if (store) begin
        ns_set_pend_q <= 1'b1;
      end
    end
  end

  // RULE21 routing to the two interrupt outputs
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      irq1_q <= 1'b0;
      irq2_q <= 1'b0;
    end else if (ce_i) begin
      irq1_q <= ns_q && new_sample_route_out1_i;
      irq2_q <= ns_q && new_sample_route_out2_i;
    end
  end

  assign reg_rdata_o = rdata_q;
  assign reg_next_addr_o = next_addr_q;
  assign new_sample_irq_flag_o = ns_q;
  assign irq_output_one_o = irq1_q;
  assign irq_output_two_o = irq2_q;
  assign wm_irq_o = wm_q;
  assign full_irq_o = full_q;
  assign overrun_o = overrun_q;
  assign frame_count_o = 7'(cnt_q);

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);

  sequence s_wm_write;
    wr_wm && !ovr_set;
  endsequence
  sequence s_flushed;
    cnt_q == '0 && !wm_q && !full_q && !overrun_q;
  endsequence

  ofs_sum_x_a: assert property ( // RULE1
    store |=> x_accel_output_q[15:4] ==
      $past(smp.x) + {{4{$past(x_offset_value_q[7])}},
      $past(x_offset_value_q)})
    else $error("X output is not sample plus offset");
  ofs_clear_a: assert property ( // RULE3
    ofs_clr |=> x_offset_value_q == 8'h00 && y_offset_value_q == 8'h00 &&
      z_offset_value_q == 8'h00)
    else $error("Offsets not cleared");
  wm_zero_off_a: assert property ( // RULE5
    watermark_level_q == 7'h00 && !wm_q |=> !wm_q)
    else $error("Watermark flag set with level zero");
  wm_flush_a: assert property ( // RULE6
    s_wm_write |=> s_flushed)
    else $error("Watermark write did not flush");
  cfg_flush_a: assert property ( // RULE7
    wr_cfg && !ovr_set |=> s_flushed)
    else $error("Configuration write did not flush");
  fill_stop_a: assert property ( // RULE23
    ovr_set && !pop && !flush |=> overrun_q && cnt_q == $past(cnt_q))
    else $error("Fill mode accepted a frame when full");
  bypass_empty_a: assert property ( // RULE24
    mode == AFO_MODE_BYPASS && cnt_q == '0 |=> cnt_q == '0)
    else $error("Bypass mode holds frames");
  port_addr_a: assert property ( // RULE14
    rd_go && addr == `AFO_ADDR_PORT |=> reg_next_addr_o == `AFO_ADDR_PORT)
    else $error("Burst address advanced at read port");
  part_drop_a: assert property ( // RULE15
    pop_part && !push |=> byte_idx_q == 3'h0 && cnt_q == $past(cnt_q) - 1)
    else $error("Partly read frame not discarded");
  ns_high_min_a: assert property ( // RULE19
    $fell(ns_q) |-> $past(ns_cnt_q) == 17'h0)
    else $error("New-sample pulse shorter than minimum");
  ns_low_min_a: assert property ( // RULE18
    $rose(ns_q) |-> $past(ns_cnt_q) == 17'h0)
    else $error("New-sample low time shorter than minimum");
  ns_rise_a: assert property ( // RULE16
    ns_enable_i && !ns_q && !ns_hold && store |=> ns_q)
    else $error("New-sample flag did not rise after store");

endmodule

// ===== bench/afo_host_model.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Host model: drives the register port one access at a time
// ---------------------------------------------------------------
module afo_host_model
  import afo_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic [7:0] reg_rdata_i,
  output afo_reg_req_s reg_req_o,
  output logic reg_burst_end_o
);
  // Idle port at time zero
  initial begin
    reg_req_o = '0;
    reg_burst_end_o = 1'h0;
  end
  // One access held over its sampling edge; released fields inverted
  task automatic acc(input logic w, input logic [7:0] a, d);
    @(posedge ref_clk_i);
    #1 reg_req_o = '{w, !w, a, d};
    @(posedge ref_clk_i);
    #1 reg_req_o = '{1'h0, 1'h0, ~a, ~d};
  endtask
  // Read data is registered on the edge that takes the request
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    acc(1'h0, a, 8'h00);
    d = reg_rdata_i;
  endtask
  // Host closes a read burst early
  task automatic burst_end();
    @(posedge ref_clk_i);
    #1 reg_burst_end_o = 1'h1;
    @(posedge ref_clk_i);
    #1 reg_burst_end_o = 1'h0;
  endtask
endmodule

// ===== bench/afo_accel_fifo_bench.sv
`timescale 1ns/1ps
module afo_accel_fifo_bench
  import afo_pkg::*;
;
  // ---------------------------------------------------------------
  // Stimulus and observed signals
  // ---------------------------------------------------------------
  logic ref_clk_i, srst_i, filt_valid_i, unf_valid_i, acq_start_i;
  logic motion_trig_i, ns_enable_i, unfiltered_sel_i;
  logic new_sample_route_out1_i, new_sample_route_out2_i;
  afo_sample_s filt_sample_i, unf_sample_i;
  afo_reg_req_s reg_req_i;
  logic reg_burst_end_i, new_sample_irq_flag_o, irq_output_one_o;
  logic irq_output_two_o, wm_irq_o, full_irq_o, overrun_o;
  logic [7:0] reg_rdata_o, reg_next_addr_o, b;
  logic [6:0] frame_count_o;
  logic [11:0] ofs [3] = '{12'h010, 12'hFF0, 12'h001};
  int n_errors = 0;
  int n_compared = 0;
  int cycles = 0;
  // Small buffer and short interrupt timing keep the run brief
  afo_accel_fifo #(.DEPTH(8), .NS_HIGH_CYC(20), .NS_LOW_CYC(5)) u_dut (
    .ref_clk_i, .srst_i, .ce_i(1'h1), .filt_sample_i, .filt_valid_i,
    .unf_sample_i, .unf_valid_i, .acq_start_i, .motion_trig_i,
    .reg_req_i, .reg_burst_end_i, .ns_enable_i, .new_sample_route_out1_i,
    .new_sample_route_out2_i, .unfiltered_sel_i, .reg_rdata_o,
    .reg_next_addr_o, .new_sample_irq_flag_o, .irq_output_one_o,
    .irq_output_two_o, .wm_irq_o, .full_irq_o, .overrun_o, .frame_count_o);
  afo_host_model u_host (.ref_clk_i, .reg_rdata_i(reg_rdata_o),
    .reg_req_o(reg_req_i), .reg_burst_end_o(reg_burst_end_i));
  // Clock and hang guard
  initial begin
    ref_clk_i = 1'h0;
    forever #2 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      n_errors++;
      final_report();
    end
  end
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Axis value of sample k: x, y, z bases differ
  function automatic logic [11:0] axv(input int k, ax);
    return 12'h120 + 12'h220 * 12'(ax) + 12'(k);
  endfunction
  function automatic logic [7:0] lo(input logic [11:0] v);
    return {v[3:0], 4'h0};
  endfunction
  task automatic chk(input string what, input logic [7:0] exp, got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  // Read a register and compare the bits under the mask
  task automatic rdc(input logic [7:0] a, e, m);
    u_host.rd(a, b);
    chk($sformatf("reg %h", a), e & m, b & m);
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  // Filtered source gets sample k, unfiltered gets its inverse
  task automatic push(input int k);
    @(posedge ref_clk_i);
    #1 filt_sample_i = '{axv(k, 0), axv(k, 1), axv(k, 2)};
    unf_sample_i = ~filt_sample_i;
    {filt_valid_i, unf_valid_i} = 2'h3;
    @(posedge ref_clk_i);
    #1 {filt_valid_i, unf_valid_i} = 2'h0;
    filt_sample_i = ~filt_sample_i;
  endtask
  // Pulse the trigger (1) or the acquisition start (0)
  task automatic pulse(input logic trig);
    @(posedge ref_clk_i);
    #1 {motion_trig_i, acq_start_i} = {trig, !trig};
    @(posedge ref_clk_i);
    #1 {motion_trig_i, acq_start_i} = 2'h0;
  endtask
  task automatic final_report();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    {srst_i, filt_valid_i, unf_valid_i, acq_start_i} = 4'h8;
    {motion_trig_i, ns_enable_i, unfiltered_sel_i} = 3'h0;
    {new_sample_route_out1_i, new_sample_route_out2_i} = 2'h2;
    {filt_sample_i, unf_sample_i} = '0;
    repeat (8) @(posedge ref_clk_i);
    #1 srst_i = 1'h0;
    foreach (ofs[i]) rdc(8'h38 + 8'(i), 8'h00, 8'hFF);
    rdc(8'h3D, 8'h00, 8'hFF);
    rdc(8'h3E, 8'h00, 8'hFF);
    // Offsets, corrected output bytes, then offset clear
    foreach (ofs[i]) u_host.acc(1'h1, 8'h38 + 8'(i), ofs[i][7:0]);
    foreach (ofs[i]) rdc(8'h38 + 8'(i), ofs[i][7:0], 8'hFF);
    push(0);
    for (int a = 0; a < 3; a++) begin
      rdc(8'(2 + 2 * a), lo(axv(0, a) + ofs[a]), 8'hFE);
      rdc(8'(3 + 2 * a), 8'((axv(0, a) + ofs[a]) >> 4), 8'hFF);
    end
    u_host.acc(1'h1, 8'h36, 8'h80);
    foreach (ofs[i]) rdc(8'h38 + 8'(i), 8'h00, 8'hFF);
    // Stream mode, watermark two, three-axis frames
    u_host.acc(1'h1, 8'h3E, 8'hC0);
    u_host.acc(1'h1, 8'h3D, 8'h02);
    push(1);
    step(2);
    chk("wm", 8'h0, wm_irq_o);
    push(2);
    step(2);
    chk("wm", 8'h1, wm_irq_o);
    u_host.acc(1'h1, 8'h3F, 8'hAA);
    chk("count", 8'h2, frame_count_o);
    for (int i = 0; i < 6; i++)
      rdc(8'h3F, i[0] ? 8'(axv(1, i / 2) >> 4) : lo(axv(1, i / 2)),
          i[0] ? 8'hFF : 8'hFE);
    chk("next addr", 8'h3F, reg_next_addr_o);
    rdc(8'h3F, lo(axv(2, 0)), 8'hFE);
    rdc(8'h3F, 8'(axv(2, 0) >> 4), 8'hFF);
    u_host.burst_end();
    step(2);
    chk("count", 8'h0, frame_count_o);
    push(3);
    u_host.acc(1'h1, 8'h3D, 8'h00);
    chk("count", 8'h0, frame_count_o);
    chk("wm", 8'h0, wm_irq_o);
    push(3);
    u_host.acc(1'h1, 8'h3E, 8'hC0);
    chk("count", 8'h0, frame_count_o);
    // Every subsampling code over eight samples
    for (int c = 0; c < 4; c++) begin
      u_host.acc(1'h1, 8'h3E, 8'hC0 | 8'(c << 2));
      for (int k = 0; k < 8; k++) push(k);
      step(2);
      chk("count", 8'(8 >> c), frame_count_o);
    end
    // Single-axis sources, two frames each
    for (int s = 1; s < 4; s++) begin
      u_host.acc(1'h1, 8'h3E, 8'hC0 | 8'(s));
      push(4);
      push(5);
      for (int f = 0; f < 2; f++) begin
        rdc(8'h3F, lo(axv(4 + f, s - 1)), 8'hFE);
        rdc(8'h3F, 8'(axv(4 + f, s - 1) >> 4), 8'hFF);
      end
    end
    // Fill-and-stop then stream, ten samples into eight slots
    for (int s = 0; s < 2; s++) begin
      u_host.acc(1'h1, 8'h3E, s ? 8'hC0 : 8'h20);
      chk("overrun", 8'h0, overrun_o);
      chk("full", 8'h0, full_irq_o);
      for (int k = 0; k < 10; k++) push(k);
      step(2);
      chk("count", 8'h8, frame_count_o);
      chk("overrun", 8'(!s), overrun_o);
      chk("full", 8'h1, full_irq_o);
      rdc(8'h3F, lo(axv(s ? 2 : 0, 0)), 8'hFE);
    end
    // Every mode code, watermark disabled
    u_host.acc(1'h1, 8'h3D, 8'h00);
    for (int m = 0; m < 8; m++) begin
      u_host.acc(1'h1, 8'h3E, 8'(m << 5));
      push(0);
      step(2);
      chk("count", 8'(m inside {1, 3, 6}), frame_count_o);
      chk("wm", 8'h0, wm_irq_o);
    end
    u_host.acc(1'h1, 8'h3E, 8'h80);
    pulse(1'h1);
    push(0);
    step(2);
    chk("count", 8'h1, frame_count_o);
    // New-sample interrupt timing and routing
    ns_enable_i = 1'h1;
    push(0);
    step(2);
    chk("flag", 8'h1, new_sample_irq_flag_o);
    chk("out one", 8'h1, irq_output_one_o);
    chk("out two", 8'h0, irq_output_two_o);
    pulse(1'h0);
    step(12);
    chk("flag", 8'h1, new_sample_irq_flag_o);
    // Early acquisition start is held until the minimum high time ends
    step(4);
    chk("flag", 8'h0, new_sample_irq_flag_o);
    // Store inside the minimum low time waits, then raises the flag
    push(1);
    step(2);
    chk("flag", 8'h0, new_sample_irq_flag_o);
    step(1);
    chk("flag", 8'h1, new_sample_irq_flag_o);
    {new_sample_route_out1_i, new_sample_route_out2_i} = 2'h1;
    step(2);
    chk("out one", 8'h0, irq_output_one_o);
    chk("out two", 8'h1, irq_output_two_o);
    // Disabled interrupt, unfiltered source selected
    {ns_enable_i, unfiltered_sel_i} = 2'h1;
    step(25);
    pulse(1'h0);
    step(10);
    push(7);
    step(10);
    chk("flag", 8'h0, new_sample_irq_flag_o);
    rdc(8'h03, ~8'(axv(7, 0) >> 4), 8'hFF);
    final_report();
  end
endmodule
